// file: hdl/serp_pkg.sv
// serp_pkg: constants and state types shared by both ends of the
// two-wire memory link.
// assumes a 50 MHz system clock on the master end.
package serp_pkg;

  ////////////////////////////////////////////////////////////////////
  // addressing byte layout
  localparam int          CTRL_RW_BIT   = 0;
  localparam int          CTRL_BLK_LSB  = 1;
  localparam int          CTRL_CODE_LSB = 4;
  // device-type code: value is arbitrary
  localparam logic [3:0]  DEV_CODE_DFLT = 4'h5;
  localparam int          DEV_ADDR_W    = 9;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;

  ////////////////////////////////////////////////////////////////////
  // timing
  localparam int          MCLK_PERIOD_NS  = 20;
  localparam int          SCL_PERIOD_NS   = 10000;
  localparam int          SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * MCLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////
  // reset values: {scl, sda, wp, supplyOk, progBusy}
  localparam logic [4:0]  DEV_SYNC_RST  = 5'h18;

  ////////////////////////////////////////////////////////////////////
  // state types
  typedef enum logic [6:0] {
    DS_IDLE  = 7'h01,
    DS_CTRL  = 7'h02,
    DS_WADDR = 7'h04,
    DS_WDATA = 7'h08,
    DS_ACK   = 7'h10,
    DS_TX    = 7'h20,
    DS_RACK  = 7'h40
  } serp_dev_state_t;

  typedef enum logic [3:0] {
    HS_IDLE  = 4'h1,
    HS_START = 4'h2,
    HS_XFER  = 4'h4,
    HS_STOP  = 4'h8
  } serp_host_state_t;

  typedef enum logic [4:0] {
    SG_CTRLW = 5'h01,
    SG_ADDR  = 5'h02,
    SG_DATA  = 5'h04,
    SG_CTRLR = 5'h08,
    SG_RDATA = 5'h10
  } serp_stage_t;

endpackage : serp_pkg

// file: hdl/serp_link_if.sv
// serp_link_if: the two-wire link between master and memory end.
// assumes the master drives the clock push-pull; data is wired-and.
`timescale 1ns/1ps
interface serp_link_if;
  logic scl;
  logic sdaHostOe;
  logic sdaHostOut;
  logic sdaDevOe;
  logic sdaDevOut;
  logic sdaLine;

  // pull-up resolution: any enabled low driver wins
  assign sdaLine = ((sdaHostOe & ~sdaHostOut) | (sdaDevOe & ~sdaDevOut)) ? 1'b0 : 1'b1;

  modport dev  (input scl, input sdaLine, output sdaDevOe, output sdaDevOut);
  modport host (output scl, output sdaHostOe, output sdaHostOut, input sdaLine);
endinterface : serp_link_if

// file: hdl/serp_sync.sv
// serp_sync: two-flop level synchroniser, any width.
// assumes each bit is an independent level.
`timescale 1ns/1ps
module serp_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : serp_sync

// file: hdl/serp_eeprom_dev.sv
// serp_eeprom_dev: memory end of the two-wire link, read path,
// pointer, protect and supply gating.
// assumes linkClk oversamples scl by at least four; pins are async.
// Contract
// - read starts like write, direction bit one
// - current, random and sequential reads supported
// - pointer holds last access plus one
// - ack read addressing byte, then send byte
// - master nack then stop ends read
// - master loads pointer via write transaction
// - repeated start abandons write, keeps pointer
// - after restart, read addressing byte, send byte
// - master ack requests next consecutive byte
// - pointer increments after each byte
// - whole array readable in one transaction
// - low supply blocks erase and write
// - data changes only while clock low
// - data change with clock high is condition
// - protect low permits reads and writes
// - protect high refuses all programming
// - reads ignore protect level
// - unused select pins are ignored
// - data line only pulled low, open drain
// - code, three block bits, direction last
// - no ack while programming busy
// - after nack, leave data line released
// - falling data with clock high is start
`timescale 1ns/1ps
module serp_eeprom_dev
  import serp_pkg::*;
#(
  parameter int         ADDR_W   = DEV_ADDR_W,
  parameter logic [3:0] DEV_CODE = DEV_CODE_DFLT
) (
  // link
  serp_link_if.dev          link,
  // clock and reset
  input  wire logic              linkClk,
  input  wire logic              rst_n,
  // pins
  input  wire logic              wpPin,
  input  wire logic              supplyOk,
  input  wire logic              progBusy,
  input  wire logic [2:0]        unusedSel,
  // status
  output logic      [ADDR_W-1:0] addrPtr
);

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers and line events
  logic [4:0]        syncQ;
  logic              sclS;
  logic              sdaS;
  logic              wpS;
  logic              supOkS;
  logic              busyS;
  logic              sclPrev_r;
  logic              sdaPrev_r;
  logic              sclRise;
  logic              sclFall;
  logic              startDet;
  logic              stopDet;

  serp_sync #(
    .W       (5),
    .RST_VAL (DEV_SYNC_RST)
  ) uSync (
    .clk   (linkClk),
    .rst_n (rst_n),
    .d     ({link.scl, link.sdaLine, wpPin, supplyOk, progBusy}),
    .q     (syncQ)
  );

  // unusedSel is left unconnected inside on purpose
  assign {sclS, sdaS, wpS, supOkS, busyS} = syncQ;

  // previous samples for edge detection
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclPrev_r <= sclS;
      sdaPrev_r <= sdaS;
    end
  end

  // data moves are only taken as bits on clock edges
  assign sclRise  = sclS & ~sclPrev_r;
  assign sclFall  = ~sclS & sclPrev_r;
  assign startDet = sclS & sclPrev_r & sdaPrev_r & ~sdaS;
  assign stopDet  = sclS & sclPrev_r & ~sdaPrev_r & sdaS;

  ////////////////////////////////////////////////////////////////////
  // state and decisions
  serp_dev_state_t   state_r;
  serp_dev_state_t   next_r;
  logic [3:0]        bitCnt_r;
  logic [7:0]        rxSh_r;
  logic [7:0]        txSh_r;
  logic [2:0]        blk_r;
  logic              masterAck_r;
  logic              sdaOe_r;
  logic [ADDR_W-1:0] ptr_r;
  logic [7:0]        mem [0:(2**ADDR_W)-1];
  logic [7:0]        rdByte;
  logic              rxState;
  logic              byteEnd;
  logic              ctrlHit;
  logic              ackGo;
  logic              txEnd;
  logic              wrEn;

  assign rdByte  = mem[ptr_r];
  assign rxState = (state_r == DS_CTRL) | (state_r == DS_WADDR) | (state_r == DS_WDATA);
  assign byteEnd = rxState & sclFall & (bitCnt_r == BYTE_BITS);
  assign ctrlHit = rxSh_r[CTRL_CODE_LSB +: 4] == DEV_CODE;
  // busy programming suppresses every ack
  assign ackGo   = byteEnd & ~busyS & ((state_r != DS_CTRL) | ctrlHit);
  assign txEnd   = (state_r == DS_TX) & sclFall & (bitCnt_r == BYTE_BITS);
  // programming needs protect low and supply good
  assign wrEn    = ackGo & (state_r == DS_WDATA) & ~wpS & supOkS;

  ////////////////////////////////////////////////////////////////////
  // protocol sequencer; start and stop override any state
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= DS_IDLE;
      next_r      <= DS_IDLE;
      bitCnt_r    <= 4'h0;
      rxSh_r      <= 8'h00;
      txSh_r      <= 8'h00;
      blk_r       <= 3'h0;
      masterAck_r <= 1'b0;
    end else if (stopDet) begin
      state_r  <= DS_IDLE;
      bitCnt_r <= 4'h0;
    end else if (startDet) begin
      state_r  <= DS_CTRL;
      bitCnt_r <= 4'h0;
    end else begin
      case (state_r)
        DS_IDLE: begin
          bitCnt_r <= 4'h0;
        end
        DS_CTRL, DS_WADDR, DS_WDATA: begin
          if (sclRise && (bitCnt_r < BYTE_BITS)) begin
            rxSh_r   <= {rxSh_r[6:0], sdaS};
            bitCnt_r <= bitCnt_r + 4'h1;
          end else if (byteEnd) begin
            state_r <= ackGo ? DS_ACK : DS_IDLE;
            if (state_r == DS_CTRL) begin
              blk_r <= rxSh_r[CTRL_BLK_LSB +: 3];
              // direction bit picks read or write
              next_r <= rxSh_r[CTRL_RW_BIT] ? DS_TX : DS_WADDR;
            end else begin
              next_r <= DS_WDATA;
            end
          end
        end
        DS_ACK: begin
          if (sclFall) begin
            state_r  <= next_r;
            bitCnt_r <= 4'h0;
            txSh_r   <= rdByte;
          end
        end
        DS_TX: begin
          if (sclRise && (bitCnt_r < BYTE_BITS)) begin
            bitCnt_r <= bitCnt_r + 4'h1;
          end else if (sclFall) begin
            txSh_r <= {txSh_r[6:0], 1'b0};
            if (bitCnt_r == BYTE_BITS) begin
              state_r <= DS_RACK;
            end
          end
        end
        DS_RACK: begin
          if (sclRise) begin
            masterAck_r <= ~sdaS;
          end else if (sclFall) begin
            bitCnt_r <= 4'h0;
            txSh_r   <= rdByte;
            // ack streams the next byte, nack parks in idle until a start
            state_r  <= masterAck_r ? DS_TX : DS_IDLE;
          end
        end
        default: begin
          state_r <= DS_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // address pointer: loaded by word address, bumped per byte
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r <= '0;
    end else if (ackGo && (state_r == DS_WADDR)) begin
      // kept across a repeated start
      ptr_r <= ADDR_W'({blk_r, rxSh_r});
    end else if ((ackGo && (state_r == DS_WDATA)) || txEnd) begin
      // natural overflow wraps to zero
      ptr_r <= ptr_r + 1'b1;
    end
  end

  assign addrPtr = ptr_r;

  ////////////////////////////////////////////////////////////////////
  // array storage; no reset, content is data not control
  always_ff @(posedge linkClk) begin
    if (wrEn) begin
      mem[ptr_r] <= rxSh_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // data line drive; updated on clock falls, released on start or stop
  // read data never looks at wpS
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      sdaOe_r <= 1'b0;
    end else if (stopDet || startDet) begin
      sdaOe_r <= 1'b0;
    end else if (byteEnd) begin
      sdaOe_r <= ackGo;
    end else if ((state_r == DS_ACK) && sclFall) begin
      sdaOe_r <= (next_r == DS_TX) ? ~rdByte[7] : 1'b0;
    end else if ((state_r == DS_TX) && sclFall) begin
      sdaOe_r <= (bitCnt_r == BYTE_BITS) ? 1'b0 : ~txSh_r[6];
    end else if ((state_r == DS_RACK) && sclFall) begin
      sdaOe_r <= masterAck_r & ~rdByte[7];
    end
  end

  // output value is always low; only the enable moves
  assign link.sdaDevOe  = sdaOe_r;
  assign link.sdaDevOut = 1'b0;

endmodule : serp_eeprom_dev

// file: hdl/serp_master_host.sv
// serp_master_host: bus master end; makes scl by dividing mclk and
// runs write, current read and random/sequential read commands.
// assumes one command at a time, offered while cmdReady is high.
`timescale 1ns/1ps
module serp_master_host
  import serp_pkg::*;
#(
  parameter int         QUARTER  = SCL_QUARTER_CYC,
  parameter int         LEN_W    = 10,
  parameter logic [3:0] DEV_CODE = DEV_CODE_DFLT
) (
  // link
  serp_link_if.host        link,
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // command
  input  wire logic             cmdValid,
  input  wire logic             cmdRead,
  input  wire logic             cmdRandom,
  input  wire logic [2:0]       cmdBlk,
  input  wire logic [7:0]       cmdAddr,
  input  wire logic [7:0]       cmdWrData,
  input  wire logic [LEN_W-1:0] cmdLen,
  // answer
  output logic                  cmdReady,
  output logic      [7:0]       rdData,
  output logic                  rdValid,
  output logic                  done,
  output logic                  nackSeen
);

  ////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [7:0] byteFor(serp_stage_t sg, logic [2:0] b, logic [7:0] a, logic [7:0] d);
    case (sg)
      SG_CTRLW: byteFor = {DEV_CODE, b, 1'b0};
      SG_CTRLR: byteFor = {DEV_CODE, b, 1'b1};
      SG_ADDR:  byteFor = a;
      SG_DATA:  byteFor = d;
      default:  byteFor = 8'hFF; // released while reading
    endcase
  endfunction : byteFor

  ////////////////////////////////////////////////////////////////////
  // quarter-period divider, idle when no command runs
  logic [15:0]      qCnt_r;
  logic             tick;
  serp_host_state_t state_r;

  assign tick = qCnt_r == 16'(QUARTER - 1);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      qCnt_r <= 16'h0000;
    end else if ((state_r == HS_IDLE) || tick) begin
      qCnt_r <= 16'h0000;
    end else begin
      qCnt_r <= qCnt_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sequencer
  logic             sdaS;
  serp_stage_t      stage_r;
  logic [1:0]       phase_r;
  logic [3:0]       bitIdx_r;
  logic [7:0]       txSh_r;
  logic [7:0]       rxSh_r;
  logic [LEN_W-1:0] left_r;
  logic             read_r;
  logic             random_r;
  logic [2:0]       blk_r;
  logic [7:0]       addr_r;
  logic [7:0]       wrData_r;
  logic             ackSeen_r;
  logic             sclOut_r;
  logic             sdaOe_r;

  serp_sync #(
    .W       (1),
    .RST_VAL (1'b1)
  ) uSdaSync (
    .clk   (mclk),
    .rst_n (rst_n),
    .d     (link.sdaLine),
    .q     (sdaS)
  );

  // every data bit changes at phase 0 with scl low; start and stop move data at phase 2 with scl high
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= HS_IDLE;
      stage_r  <= SG_CTRLW;
      phase_r  <= 2'h0;
      bitIdx_r <= 4'h0;
      txSh_r   <= 8'hFF;
      rxSh_r   <= 8'h00;
      left_r   <= '0;
      read_r   <= 1'b0;
      random_r <= 1'b0;
      blk_r    <= 3'h0;
      addr_r   <= 8'h00;
      wrData_r <= 8'h00;
      ackSeen_r <= 1'b0;
      sclOut_r <= 1'b1;
      sdaOe_r  <= 1'b0;
      cmdReady <= 1'b1;
      rdData   <= 8'h00;
      rdValid  <= 1'b0;
      done     <= 1'b0;
      nackSeen <= 1'b0;
    end else begin
      rdValid <= 1'b0;
      done    <= 1'b0;
      if (state_r == HS_IDLE) begin
        phase_r <= 2'h0;
        if (cmdValid) begin
          read_r   <= cmdRead;
          random_r <= cmdRandom;
          blk_r    <= cmdBlk;
          addr_r   <= cmdAddr;
          wrData_r <= cmdWrData;
          left_r   <= (cmdLen == '0) ? LEN_W'(1) : cmdLen;
          // a random read first loads the pointer by a write
          stage_r  <= (cmdRead && !cmdRandom) ? SG_CTRLR : SG_CTRLW;
          state_r  <= HS_START;
          cmdReady <= 1'b0;
          nackSeen <= 1'b0;
        end
      end else if (tick) begin
        phase_r <= phase_r + 2'h1;
        case (state_r)
          HS_START: begin
            case (phase_r)
              2'h0: sdaOe_r <= 1'b0;
              2'h1: sclOut_r <= 1'b1;
              2'h2: sdaOe_r <= 1'b1; // falling data, clock high
              default: begin
                sclOut_r <= 1'b0;
                state_r  <= HS_XFER;
                bitIdx_r <= 4'h0;
                txSh_r   <= byteFor(stage_r, blk_r, addr_r, wrData_r);
              end
            endcase
          end
          HS_XFER: begin
            case (phase_r)
              2'h0: sdaOe_r <= (bitIdx_r < BYTE_BITS) ? ~txSh_r[7]
                             : ((stage_r == SG_RDATA) && (left_r > LEN_W'(1)));
              2'h1: sclOut_r <= 1'b1;
              2'h2: begin
                if (bitIdx_r < BYTE_BITS) begin
                  rxSh_r <= {rxSh_r[6:0], sdaS};
                end else begin
                  ackSeen_r <= ~sdaS;
                end
              end
              default: begin
                sclOut_r <= 1'b0;
                bitIdx_r <= 4'h0;
                if (bitIdx_r < BYTE_BITS) begin
                  bitIdx_r <= bitIdx_r + 4'h1;
                  txSh_r   <= {txSh_r[6:0], 1'b1};
                end else if ((stage_r != SG_RDATA) && !ackSeen_r) begin
                  nackSeen <= 1'b1;
                  state_r  <= HS_STOP;
                end else begin
                  case (stage_r)
                    SG_CTRLW: begin
                      stage_r <= SG_ADDR;
                      txSh_r  <= addr_r;
                    end
                    SG_ADDR: begin
                      if (read_r) begin
                        stage_r <= SG_CTRLR; // repeated start
                        state_r <= HS_START;
                      end else begin
                        stage_r <= SG_DATA;
                        txSh_r  <= wrData_r;
                      end
                    end
                    SG_CTRLR: begin
                      stage_r <= SG_RDATA;
                      txSh_r  <= 8'hFF;
                    end
                    SG_RDATA: begin
                      rdData  <= rxSh_r;
                      rdValid <= 1'b1;
                      txSh_r  <= 8'hFF;
                      left_r  <= left_r - LEN_W'(1);
                      if (left_r == LEN_W'(1)) begin
                        state_r <= HS_STOP;
                      end
                    end
                    default: state_r <= HS_STOP;
                  endcase
                end
              end
            endcase
          end
          HS_STOP: begin
            case (phase_r)
              2'h0: sdaOe_r <= 1'b1;
              2'h1: sclOut_r <= 1'b1;
              2'h2: sdaOe_r <= 1'b0;
              default: begin
                state_r  <= HS_IDLE;
                cmdReady <= 1'b1;
                done     <= 1'b1;
              end
            endcase
          end
          default: state_r <= HS_IDLE;
        endcase
      end
    end
  end

  assign link.scl        = sclOut_r;
  assign link.sdaHostOe  = sdaOe_r;
  assign link.sdaHostOut = 1'b0;

endmodule : serp_master_host

// file: testbench/serp_link_chk.sv
// serp_link_chk: level and timing checks on the two-wire link.
// assumes it samples on the master clock; device outputs move on linkClk.
`timescale 1ns/1ps
module serp_link_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // link
  input wire logic scl,
  input wire logic sdaHostOe,
  input wire logic sdaHostOut,
  input wire logic sdaDevOe,
  input wire logic sdaDevOut,
  input wire logic sdaLine
);
  logic [7:0] lowCnt_r;

  ////////////////////////////////////////////////////////////////////
  // cycles since scl fell; saturates so long idle gaps are harmless
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) lowCnt_r <= 8'h00;
    else if (scl) lowCnt_r <= 8'h00;
    else if (lowCnt_r != 8'hFF) lowCnt_r <= lowCnt_r + 8'h01;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////
  dev_drive_low_a: assert property (sdaDevOut == 1'b0)
    else $error("device drives data high");
  host_drive_low_a: assert property (sdaHostOut == 1'b0)
    else $error("master drives data high");
  wire_and_a: assert property (sdaLine == !(sdaHostOe || sdaDevOe))
    else $error("data line not wired-and");
  dev_high_stable_a: assert property (scl && $past(scl) |-> $stable(sdaDevOe))
    else $error("device changed data while clock high");
  dev_prompt_a: assert property ($changed(sdaDevOe) |-> !scl && lowCnt_r <= 8'h14)
    else $error("device data change late in low phase");
  clock_hold_a: assert property ($changed(scl) |=> $stable(scl) [*8])
    else $error("clock phase too short");
  start_quiet_a: assert property (scl && $past(scl) && $fell(sdaLine) |-> !sdaDevOe [*8])
    else $error("device drove data after start");
  stop_release_a: assert property (scl && $past(scl) && $rose(sdaLine) |=> !sdaDevOe [*8])
    else $error("device drove data after stop");
endmodule : serp_link_chk

// file: testbench/test_serial_eeprom_read_path.sv
// test_serial_eeprom_read_path: master and memory ends joined by the link.
// assumes both ends share the device code and a shortened bus quarter.
`timescale 1ns/1ps
module test_serial_eeprom_read_path;
  import serp_pkg::*;
  localparam int LIMIT = 90000;

  logic       mclk, linkClk, rst_n;
  logic       cmdValid, cmdRead, cmdRandom;
  logic [2:0] cmdBlk, unusedSel;
  logic [7:0] cmdAddr, cmdWrData, rdData;
  logic [9:0] cmdLen;
  logic       cmdReady, rdValid, done, nackSeen;
  logic       wpPin, supplyOk, progBusy;
  logic [8:0] addrPtr;
  logic [7:0] rxQ[$];
  int         errCount, nCompared, cycleCnt;

  serp_link_if link ();

  serp_master_host #(.QUARTER(20), .LEN_W(10), .DEV_CODE(DEV_CODE_DFLT)) serp_master_host_i (
    .link(link.host), .mclk(mclk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdRead(cmdRead),
    .cmdRandom(cmdRandom), .cmdBlk(cmdBlk), .cmdAddr(cmdAddr), .cmdWrData(cmdWrData),
    .cmdLen(cmdLen), .cmdReady(cmdReady), .rdData(rdData), .rdValid(rdValid), .done(done),
    .nackSeen(nackSeen));

  serp_eeprom_dev #(.ADDR_W(9), .DEV_CODE(DEV_CODE_DFLT)) serp_eeprom_dev_i (
    .link(link.dev), .linkClk(linkClk), .rst_n(rst_n), .wpPin(wpPin), .supplyOk(supplyOk),
    .progBusy(progBusy), .unusedSel(unusedSel), .addrPtr(addrPtr));

  serp_link_chk serp_link_chk_i (
    .mclk(mclk), .rst_n(rst_n), .scl(link.scl), .sdaHostOe(link.sdaHostOe),
    .sdaHostOut(link.sdaHostOut), .sdaDevOe(link.sdaDevOe), .sdaDevOut(link.sdaDevOut),
    .sdaLine(link.sdaLine));

  ////////////////////////////////////////////////////////////////////
  // clocks: link clock offset so the two never line up
  initial begin
    mclk = 1'b0;
    linkClk = 1'b0;
    #7;
    forever #40 linkClk = ~linkClk;
  end
  always #10 mclk = ~mclk;

  // hang guard
  always @(posedge mclk) begin
    cycleCnt++;
    if (cycleCnt == LIMIT) begin
      errCount++;
      completeRun();
    end
  end

  ////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one command, collecting read bytes until done
  task automatic runCmd(input logic rd, input logic rnd, input logic [8:0] adr,
                        input logic [7:0] wd, input logic [9:0] len);
    rxQ = {};
    while (cmdReady !== 1'b1) @(posedge mclk);
    @(posedge mclk) #1;
    {cmdRead, cmdRandom, cmdBlk, cmdAddr, cmdWrData, cmdLen} = {rd, rnd, 2'h0, adr, wd, len};
    cmdValid = 1'b1;
    @(posedge mclk) #1;
    cmdValid = 1'b0;
    repeat (20000) begin
      @(posedge mclk) #1;
      if (rdValid === 1'b1) rxQ.push_back(rdData);
      if (done === 1'b1) break;
    end
    // a command that never reaches its stop counts against the run
    check("cmd done", 16'h0001, {15'h0000, done});
  endtask : runCmd

  task automatic wrByte(input logic [8:0] adr, input logic [7:0] wd);
    runCmd(1'b0, 1'b0, adr, wd, 10'h001);
  endtask : wrByte

  ////////////////////////////////////////////////////////////////////
  // writes, then a two-byte random read across a restart
  task automatic testRandomSeq();
    unusedSel = 3'h5;
    wrByte(9'h010, 8'hA5);
    wrByte(9'h011, 8'h3C);
    wrByte(9'h1FF, 8'h77);
    wrByte(9'h000, 8'h88);
    runCmd(1'b1, 1'b1, 9'h010, 8'h00, 10'h002);
    check("seq count", 16'h0002, 16'(rxQ.size()));
    check("seq byte0", 16'h00A5, {8'h00, rxQ[0]});
    check("seq byte1", 16'h003C, {8'h00, rxQ[1]});
    check("seq pointer", 16'h0012, {7'h00, addrPtr});
    check("seq nack", 16'h0000, {15'h0000, nackSeen});
    $display("test random sequential read done");
  endtask : testRandomSeq

  // current read after a write returns the next location
  task automatic testCurrent();
    unusedSel = 3'h2;
    wrByte(9'h013, 8'hC3);
    wrByte(9'h012, 8'h5A);
    runCmd(1'b1, 1'b0, 9'h000, 8'h00, 10'h001);
    check("current count", 16'h0001, 16'(rxQ.size()));
    check("current byte", 16'h00C3, {8'h00, rxQ[0]});
    check("current pointer", 16'h0014, {7'h00, addrPtr});
    $display("test current read done");
  endtask : testCurrent

  // read across the top of the array
  task automatic testWrap();
    unusedSel = 3'h7;
    runCmd(1'b1, 1'b1, 9'h1FF, 8'h00, 10'h002);
    check("wrap byte0", 16'h0077, {8'h00, rxQ[0]});
    check("wrap byte1", 16'h0088, {8'h00, rxQ[1]});
    check("wrap pointer", 16'h0001, {7'h00, addrPtr});
    $display("test wrap done");
  endtask : testWrap

  // protect high, then low supply: writes acked but not stored
  task automatic testProtect();
    unusedSel = 3'h0;
    wpPin = 1'b1;
    wrByte(9'h010, 8'h00);
    check("protect nack", 16'h0000, {15'h0000, nackSeen});
    runCmd(1'b1, 1'b1, 9'h010, 8'h00, 10'h001);
    check("protect byte", 16'h00A5, {8'h00, rxQ[0]});
    wpPin = 1'b0;
    supplyOk = 1'b0;
    wrByte(9'h011, 8'h00);
    supplyOk = 1'b1;
    runCmd(1'b1, 1'b1, 9'h011, 8'h00, 10'h001);
    check("supply byte", 16'h003C, {8'h00, rxQ[0]});
    $display("test protect done");
  endtask : testProtect

  // programming busy: no acknowledge, no data
  task automatic testBusy();
    progBusy = 1'b1;
    runCmd(1'b1, 1'b0, 9'h000, 8'h00, 10'h001);
    progBusy = 1'b0;
    check("busy nack", 16'h0001, {15'h0000, nackSeen});
    check("busy count", 16'h0000, 16'(rxQ.size()));
    runCmd(1'b1, 1'b1, 9'h012, 8'h00, 10'h001);
    check("after busy", 16'h005A, {8'h00, rxQ[0]});
    $display("test busy done");
  endtask : testBusy

  ////////////////////////////////////////////////////////////////////
  task automatic completeRun();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : completeRun

  initial begin
    {cmdValid, cmdRead, cmdRandom, cmdBlk, cmdAddr, cmdWrData} = '0;
    cmdLen = 10'h001;
    // protect low, supply good, not busy, select pins at zero
    {wpPin, supplyOk, progBusy, unusedSel} = 6'h10;
    rst_n = 1'b0;
    repeat (10) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (20) @(posedge mclk);
    testRandomSeq();
    testCurrent();
    testWrap();
    testProtect();
    testBusy();
    completeRun();
  end
endmodule : test_serial_eeprom_read_path
